/* bench/sector_erase_status_sequencer_tb.sv */
/*
  Self-checking bench for the erase status sequencer.
  Assumes shortened erase timings; timeout window stays 350 cycles.
*/
`timescale 1ns/1ps
module sector_erase_status_sequencer_tb;
  typedef struct {logic [31:0] m; logic [31:0] e;} sess_note_t;
  logic        hclk, hresetn, irq, hready, hresp, hwrite, dp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata, rnd, q;
  int          fails, n_checks, t;
  sess_note_t  notes[$];
  sess_note_t  nt;
  // limit sits between a two-sector erase with restart and an eight-sector erase
  sess_top #(.ERASE_CYC(30), .PREP_CYC(5), .LIMIT_CYC(600)) uut (.hclk(hclk),
    .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .irq(irq));
  sess_host host (.hclk(hclk), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task final_report;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    notes.push_back('{m, e});
    host.xfer(1'b0, a, 32'h0, q);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task width(input logic [1:0] w);
    host.access_width = w;
    rd(12'h014, 32'h0, 32'h0);
  endtask
  task wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    t = $time / 100;
    check("irq", {31'h0, irq}, 32'h1);
  endtask
  task erase(input logic [7:0] s, input int gap);
    int t0;
    width(2'h1);
    // with a gap, the other sectors join later inside the window
    wr(12'h010, {24'h0, (gap > 0) ? s & ~(s - 8'h1) : s});
    wr(12'h000, 32'h30);
    if (gap > 0) begin
      repeat (gap) @(posedge hclk);
      wr(12'h010, {24'h0, s});
      wr(12'h000, 32'h30);
    end
    t0 = $time / 100;
    wr(12'h000, 32'hF0);
    while ($time / 100 < t0 + 345) @(posedge hclk);
    rd(12'h004, 32'h8, 32'h0);
    while ($time / 100 < t0 + 353) @(posedge hclk);
    rd(12'h004, 32'h8, 32'h8);
    rd(12'h004, 32'h0, 32'h0);
    wait_irq;
    // 350 window plus 35 per sector; wait_irq sees irq one edge late
    check("erase_len", t - t0, 351 + $countones(s) * 35);
    rd(12'h004, 32'h80, 32'h80);
    rd(12'h014, 32'h7, 32'h0);
    rd(12'h008, 32'h7, 32'h5);
    wr(12'h008, 32'h7);
    #1 check("irq_clear", {31'h0, irq}, 32'h0);
    width(2'h2);
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (dp && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.m != 32'h0) check("rdata", hrdata & nt.m, nt.e);
    end
    dp <= htrans[1] && !hwrite;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    fails++;
    final_report;
  end
  initial begin
    // start high so the drop is a true falling edge for every flop
    hresetn = 1'b1;
    dp = 1'b0;
    rnd = 32'hC71241F3;
    #10 hresetn = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rnd = xs(rnd);
    rd(12'h018 + {rnd[9:2], 2'b00}, 32'hFFFFFFFF, 32'h0);
    wr(12'h00C, 32'h3);
    for (int i = 0; i < 2; i++) begin
      rnd = xs(rnd);
      erase((8'h1 << rnd[2:0]) | (8'h1 << rnd[5:3]), i * 100);
    end
    width(2'h1);
    wr(12'h010, 32'hFF);
    wr(12'h000, 32'h30);
    wait_irq;
    rd(12'h004, 32'hE0, 32'hE0);
    rd(12'h004, 32'hE0, 32'hE0);
    rd(12'h004, 32'h80, 32'h80);
    rd(12'h004, 32'h40, 32'h40);
    rd(12'h008, 32'h2, 32'h2);
    wr(12'h008, 32'h7);
    width(2'h2);
    width(2'h1);
    wr(12'h010, 32'h1);
    wr(12'h000, 32'h30);
    repeat (360) @(posedge hclk);
    wr(12'h000, 32'hB0);
    rd(12'h008, 32'h4, 32'h0);
    wr(12'h000, 32'h50);
    rd(12'h004, 32'h8, 32'h8);
    wait_irq;
    wr(12'h008, 32'h7);
    width(2'h2);
    repeat (3) @(posedge hclk);
    final_report;
  end
endmodule
bind sess_top sess_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

/* bench/sess_asserts.sv */
/*
  Port checker for the erase status sequencer.
  Assumes one clock, async low reset, zero-wait slave.
*/
`timescale 1ns/1ps
module sess_asserts (
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // bus
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // interrupt
  input wire logic        irq
);
  logic take;
  logic rd_dp, st_dp, un_dp, busy, tog;
  logic next_rd_dp, next_st_dp, next_un_dp, next_busy, next_tog;
  always_comb begin
    take       = hsel && htrans[1] && hready && !hwrite;
    next_rd_dp = take;
    next_st_dp = take && haddr == 12'h004;
    next_un_dp = take && haddr > 12'h014;
    next_busy  = busy && !(hsel && htrans[1] && hready && !(take && haddr == 12'h004));
    next_tog   = tog;
    // any other access may flip toggle, so history is dropped
    if (rd_dp) begin
      next_busy = st_dp && hrdata[3] && !hrdata[7] && !hrdata[5];
      next_tog  = hrdata[6];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {rd_dp, st_dp, un_dp, busy, tog} <= 5'h0;
    end else begin
      {rd_dp, st_dp, un_dp, busy, tog} <=
        {next_rd_dp, next_st_dp, next_un_dp, next_busy, next_tog};
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  zero_wait_a: assert property (hreadyout) else $error("slave inserted a wait");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  poll_with_limit_a: assert property (st_dp && hrdata[5] |-> hrdata[7])
    else $error("timing limit without polling flag");
  toggle_stop_a: assert property (st_dp && hrdata[5] |-> hrdata[6])
    else $error("timing limit without toggle flag");
  toggle_flip_a: assert property (st_dp && busy && hrdata[3] && !hrdata[7] && !hrdata[5]
    |-> hrdata[6] != tog) else $error("toggle did not flip");
  rdata_hold_a: assert property (!rd_dp |-> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (un_dp |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  reset_idle_a: assert property (disable iff (1'b0) !hresetn |-> hrdata == 32'h0 && !irq)
    else $error("outputs not idle in reset");
  cover property (st_dp && hrdata[5]);
  cover property (st_dp && hrdata[7]);
  cover property ($rose(irq));
endmodule

/* bench/sess_host.sv */
/*
  Bus master model standing for the cpu side.
  Assumes tasks are entered just after a rising hclk edge.
*/
`timescale 1ns/1ps
module sess_host (
  // clock
  input wire logic         hclk,
  // master outputs
  output logic [11:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [31:0]      hwdata,
  // slave answer
  input wire logic         hready,
  input wire logic [31:0]  hrdata
);
  // 1 is 16-bit, 2 is 32-bit; set around each erase with a dummy read
  logic [1:0] access_width;
  initial begin
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    access_width = 2'h2;
  end
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
endmodule

/* design/sess_counter.sv */
/*
  Down counter with load and done pulse, used for the phase timers.
  Assumes loads and runs from the same clock as the sequencer.
*/
`timescale 1ns/1ps
module sess_counter #(
  parameter int W = 16
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  // status
  output logic              done
);
  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic         next_done;

  always_comb begin
    next_cnt  = cnt;
    next_done = 1'b0;
    if (load) begin
      next_cnt = load_val;
    end else if (run && cnt != '0) begin
      next_cnt  = cnt - W'(1);
      next_done = (cnt == W'(1));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= '0;
      done <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      done <= next_done;
    end
  end
endmodule

/* design/sess_defs.svh */
/*
  Constants for the sector erase status sequencer: register offsets,
  status bit positions, command codes and timing counts.
  Assumes a 10 MHz hclk; included by bare name.
*/
`ifndef SESS_DEFS_SVH
`define SESS_DEFS_SVH

// register byte offsets
`define SESS_OFF_CMD          12'h000
`define SESS_OFF_STATUS       12'h004
`define SESS_OFF_IRQ_STAT     12'h008
`define SESS_OFF_IRQ_MASK     12'h00C
`define SESS_OFF_SECT_SEL     12'h010
`define SESS_OFF_CTRL         12'h014

// command codes (low byte of a command write)
`define SESS_CMD_ERASE        8'h30
`define SESS_CMD_SUSPEND      8'hB0
`define SESS_CMD_RESUME       8'h50
`define SESS_CMD_RESET        8'hF0

// status word bit positions
`define SESS_BIT_POLL         7
`define SESS_BIT_TOGGLE       6
`define SESS_BIT_LIMIT        5
`define SESS_BIT_TIMER        3

// irq bit positions
`define SESS_IRQ_DONE         0
`define SESS_IRQ_LIMIT        1
`define SESS_IRQ_IGNORED      2

// timing
`define SESS_CLK_MHZ          10
`define SESS_TIMEOUT_US       35
`define SESS_TIMEOUT_CYC      (`SESS_TIMEOUT_US * `SESS_CLK_MHZ)
`define SESS_ERASE_CYC        2000
`define SESS_PREPROG_CYC      500
`define SESS_LIMIT_CYC        8000

`endif

/* design/sess_pkg.sv */
/*
  Types for the sector erase status sequencer.
  Assumes the defs header for all numeric constants.
*/
package sess_pkg;

  typedef enum logic [2:0] {
    SESS_READ    = 3'b000,
    SESS_TIMEOUT = 3'b001,
    SESS_PREPROG = 3'b010,
    SESS_ERASE   = 3'b011,
    SESS_SUSPEND = 3'b100
  } sess_state_t;

  typedef struct packed {
    logic data_polling_flag;
    logic toggle;
    logic timing_limit_exceeded_flag;
    logic timer;
  } sess_flags_t;

endpackage

/* design/sess_top.sv */
/*
  Sector erase status sequencer behind an AHB-Lite slave.
  Assumes a single AHB-Lite master, word transfers, hclk at 10 MHz.
*/
// Local design decisions: the register offsets and register access over AHB-Lite.
// Notes on behaviour
// - erase completion returns the block to read/reset mode
// - erase time is (erase + preprogram) per selected sector
// - data-polling flag changes together with the timing-limit flag
// - toggle stops when toggle and timing-limit both become one
// - during erase and timeout only erase and suspend commands act
// - status-offset reads during erase return the flags, bit 7 data-polling; other offsets decode as usual
// - erase starts 35 us after last erase code; more codes extend
`timescale 1ns/1ps
`include "sess_defs.svh"
module sess_top #(
  parameter int NSECT     = 8,
  parameter int ERASE_CYC = `SESS_ERASE_CYC,
  parameter int PREP_CYC  = `SESS_PREPROG_CYC,
  parameter int LIMIT_CYC = `SESS_LIMIT_CYC
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // interrupt
  output logic             irq
);
  // counters act one edge after reaching zero, so load one less; phases need at least 2
  localparam logic [15:0] TO_CYC   = 16'(`SESS_TIMEOUT_CYC - 1);
  localparam logic [15:0] PREP_LD  = 16'(PREP_CYC - 1);
  localparam logic [15:0] ERASE_LD = 16'(ERASE_CYC - 1);

  sess_pkg::sess_state_t state;
  sess_pkg::sess_state_t next_state;
  sess_pkg::sess_state_t resume_state;
  sess_pkg::sess_state_t next_resume_state;
  sess_pkg::sess_flags_t flags;
  sess_pkg::sess_flags_t next_flags;

  logic [NSECT-1:0] sect;
  logic [NSECT-1:0] next_sect;
  logic [NSECT-1:0] pend;
  logic [NSECT-1:0] next_pend;
  logic [2:0]       irq_stat;
  logic [2:0]       next_irq_stat;
  logic [2:0]       irq_mask;
  logic [2:0]       next_irq_mask;
  logic [31:0]      next_hrdata;
  logic [31:0]      limit_cnt;
  logic [31:0]      next_limit_cnt;
  logic             a_valid;
  logic             a_write;
  logic [11:0]      a_addr;

  // phase timers
  logic to_load;
  logic to_done;
  logic ph_load;
  logic ph_done;
  logic [15:0] ph_val;

  sess_counter #(.W(16)) u_timeout (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (to_load),
    .load_val (TO_CYC),
    .run      (state == sess_pkg::SESS_TIMEOUT),
    .done     (to_done)
  );

  sess_counter #(.W(16)) u_phase (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (ph_load),
    .load_val (ph_val),
    .run      (state == sess_pkg::SESS_PREPROG || state == sess_pkg::SESS_ERASE),
    .done     (ph_done)
  );

  function automatic int first_set(input logic [NSECT-1:0] v);
    int idx;
    idx = -1;
    for (int i = NSECT - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = i;
      end
    end
    return idx;
  endfunction

  // zero-wait slave: address phase captured, data phase acted on
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(irq_stat & irq_mask);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_addr  <= 12'h000;
    end else if (hready) begin
      a_valid <= hsel && htrans[1];
      a_write <= hwrite;
      a_addr  <= haddr;
    end
  end

  logic wr;
  logic rd_next;
  logic busy;
  logic [7:0] cmd;
  assign wr      = a_valid && a_write;
  assign rd_next = hsel && htrans[1] && !hwrite && hready;
  assign cmd     = hwdata[7:0];
  assign busy    = state != sess_pkg::SESS_READ;

  always_comb begin
    next_state        = state;
    next_resume_state = resume_state;
    next_flags        = flags;
    next_sect         = sect;
    next_pend         = pend;
    next_irq_mask     = irq_mask;
    next_irq_stat     = irq_stat;
    next_limit_cnt    = limit_cnt;
    to_load           = 1'b0;
    ph_load           = 1'b0;
    ph_val            = PREP_LD;
    // software clear first so hardware sets below win
    if (wr && a_addr == `SESS_OFF_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~hwdata[2:0];
    end
    if (wr && a_addr == `SESS_OFF_IRQ_MASK) begin
      next_irq_mask = hwdata[2:0];
    end
    if (wr && a_addr == `SESS_OFF_SECT_SEL && (!busy || state == sess_pkg::SESS_TIMEOUT)) begin
      next_sect = hwdata[NSECT-1:0];
    end
    if (wr && a_addr == `SESS_OFF_CMD) begin
      unique case (state)
        sess_pkg::SESS_READ: begin
          if (cmd == `SESS_CMD_ERASE && sect != '0) begin
            next_pend          = sect;
            next_flags         = '0;
            next_flags.timer   = 1'b0;
            next_limit_cnt     = '0;
            to_load            = 1'b1;
            next_state         = sess_pkg::SESS_TIMEOUT;
          end
        end
        sess_pkg::SESS_TIMEOUT: begin
          if (cmd == `SESS_CMD_ERASE) begin
            next_pend = pend | sect;
            to_load   = 1'b1;
          end else if (cmd == `SESS_CMD_SUSPEND) begin
            next_resume_state = sess_pkg::SESS_PREPROG;
            next_state        = sess_pkg::SESS_SUSPEND;
          end else begin
            next_irq_stat[`SESS_IRQ_IGNORED] = 1'b1;
          end
        end
        sess_pkg::SESS_PREPROG, sess_pkg::SESS_ERASE: begin
          if (cmd == `SESS_CMD_SUSPEND) begin
            next_resume_state = state;
            next_state        = sess_pkg::SESS_SUSPEND;
          end else if (cmd != `SESS_CMD_ERASE) begin
            // late erase codes are accepted silently but not added
            next_irq_stat[`SESS_IRQ_IGNORED] = 1'b1;
          end
        end
        sess_pkg::SESS_SUSPEND: begin
          if (cmd == `SESS_CMD_RESUME) begin
            next_state = resume_state;
            ph_load    = 1'b1;
            ph_val     = (resume_state == sess_pkg::SESS_ERASE) ? ERASE_LD
                                                               : PREP_LD;
          end
        end
        default: next_state = sess_pkg::SESS_READ;
      endcase
    end
    // sequencing; one sector costs preprogram plus erase
    if (state == sess_pkg::SESS_TIMEOUT && to_done && next_state == state) begin
      next_flags.timer = 1'b1;
      ph_load          = 1'b1;
      ph_val           = PREP_LD;
      next_state       = sess_pkg::SESS_PREPROG;
    end
    if (ph_done && next_state == state) begin
      if (state == sess_pkg::SESS_PREPROG) begin
        ph_load    = 1'b1;
        ph_val     = ERASE_LD;
        next_state = sess_pkg::SESS_ERASE;
      end else if (state == sess_pkg::SESS_ERASE) begin
        next_pend[first_set(pend)] = 1'b0;
        if ((pend & (pend - NSECT'(1))) == '0) begin
          next_flags.data_polling_flag = 1'b1;
          next_irq_stat[`SESS_IRQ_DONE] = 1'b1;
          next_state = sess_pkg::SESS_READ;
        end else begin
          ph_load    = 1'b1;
          ph_val     = PREP_LD;
          next_state = sess_pkg::SESS_PREPROG;
        end
      end
    end
    // timing limit: polling and toggle settle in the same cycle as the limit flag
    if (busy && state != sess_pkg::SESS_SUSPEND && !flags.timing_limit_exceeded_flag) begin
      next_limit_cnt = limit_cnt + 32'(1);
      if (limit_cnt == 32'(LIMIT_CYC - 1)) begin
        next_flags.timing_limit_exceeded_flag = 1'b1;
        next_flags.data_polling_flag          = 1'b1;
        next_flags.toggle                     = 1'b1;
        next_irq_stat[`SESS_IRQ_LIMIT] = 1'b1;
      end
    end
    // toggle inverts on every read of any offset while busy and the limit flag is clear, suspend included; the limit flag clears only on erase from read
    if (rd_next && busy && !next_flags.timing_limit_exceeded_flag) begin
      next_flags.toggle = ~flags.toggle;
    end
    if (flags.timing_limit_exceeded_flag && busy && next_state == state) begin
      // halt on limit: leave algorithm with flags frozen
      next_state = sess_pkg::SESS_READ;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state        <= sess_pkg::SESS_READ;
      resume_state <= sess_pkg::SESS_PREPROG;
      flags        <= '0;
      sect         <= '0;
      pend         <= '0;
      irq_stat     <= 3'h0;
      irq_mask     <= 3'h0;
      limit_cnt    <= 32'h0;
      hrdata       <= 32'h0;
    end else begin
      state        <= next_state;
      resume_state <= next_resume_state;
      flags        <= next_flags;
      sect         <= next_sect;
      pend         <= next_pend;
      irq_stat     <= next_irq_stat;
      irq_mask     <= next_irq_mask;
      limit_cnt    <= next_limit_cnt;
      hrdata       <= next_hrdata;
    end
  end

  // read data registered at the address phase so it stands in the data phase
  always_comb begin
    next_hrdata = hrdata;
    if (rd_next) begin
      next_hrdata = 32'h0;
      unique case (haddr)
        `SESS_OFF_STATUS: begin
          next_hrdata[`SESS_BIT_POLL]   = flags.data_polling_flag;
          next_hrdata[`SESS_BIT_TOGGLE] = flags.toggle;
          next_hrdata[`SESS_BIT_LIMIT]  = flags.timing_limit_exceeded_flag;
          next_hrdata[`SESS_BIT_TIMER]  = flags.timer;
        end
        `SESS_OFF_IRQ_STAT: next_hrdata[2:0] = irq_stat;
        `SESS_OFF_IRQ_MASK: next_hrdata[2:0] = irq_mask;
        `SESS_OFF_SECT_SEL: next_hrdata[NSECT-1:0] = sect;
        `SESS_OFF_CTRL:     next_hrdata[2:0] = state;
        default:            next_hrdata = 32'h0;
      endcase
    end
  end
endmodule
